// [common/lsdc_regs.vh]
`ifndef LSDC_REGS_VH
`define LSDC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LSDC_OFF_L1_CAP        12'h244
`define LSDC_OFF_L1_CTL_ONE    12'h248
`define LSDC_OFF_L1_CTL_TWO    12'h24C
`define LSDC_OFF_CNT_HDR       12'h250
`define LSDC_OFF_CNT_CAP_CTL   12'h254
`define LSDC_OFF_CNT_STATUS    12'h258

// ----------------------------------------------------------------------
// L1 substates capability and control fields
// ----------------------------------------------------------------------
`define LSDC_L1_PCIPM_BIT      1
`define LSDC_L1_ASPM_BIT       3
`define LSDC_L1_SUBST_BIT      4
`define LSDC_RST_PCIPM_SUP     1'h1
`define LSDC_RST_ASPM_SUP      1'h0
`define LSDC_RST_SUBST_SUP     1'h1

// ----------------------------------------------------------------------
// Containment header, capability, control, status
// ----------------------------------------------------------------------
`define LSDC_HDR_VALUE         32'h0001001D
`define LSDC_MSG_NUM_RST       5'h01
`define LSDC_MSG_NUM_HI        4
`define LSDC_MSG_NUM_LO        0
`define LSDC_BE_LOW            0
`define LSDC_BE_CTL            2
`define LSDC_TRIG_LO           16
`define LSDC_TRIG_HI           17
`define LSDC_CPL_BIT           18
`define LSDC_INT_EN_BIT        19
`define LSDC_COR_EN_BIT        20
`define LSDC_TRIG_OFF          2'h0
`define LSDC_TRIG_FATAL        2'h1
`define LSDC_TRIG_ANY          2'h2
`define LSDC_RSN_UNCOR         2'h0
`define LSDC_RSN_NONFATAL      2'h1
`define LSDC_RSN_FATAL         2'h2
`define LSDC_ST_TRIG_BIT       0
`define LSDC_ST_RSN_LO         1
`define LSDC_ST_RSN_HI         2
`define LSDC_ST_INT_BIT        3

`endif

// [core/lsdc_sync.v]
`timescale 1ns/10ps
`default_nettype none

module lsdc_sync
(
    input  wire mclk,
    input  wire rst_n,
    input  wire d,
    output wire q
);

    reg meta_r;
    reg q_r;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end
        else
        begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end

    assign q = q_r;

endmodule // lsdc_sync

`default_nettype wire

// [core/lsdc_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "lsdc_regs.vh"

module lsdc_top
(
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        cfg_rd,
    input  wire        cfg_wr,
    input  wire [11:0] cfg_addr,
    input  wire [31:0] cfg_wdata,
    input  wire [3:0]  cfg_be,
    output wire [31:0] cfg_rdata,
    output wire        cfg_rvalid,
    input  wire        ld_wr,
    input  wire [2:0]  ld_sup,
    input  wire        is_downstream,
    input  wire        uncor_err,
    input  wire        rx_nonfatal,
    input  wire        rx_fatal,
    output wire        pcipm_l11_en,
    output wire        aspm_l11_en,
    output wire        cont_active,
    output wire        cpl_ur_sel,
    output wire        cont_irq,
    output wire        cont_err_cor
);

    // ------------------------------------------------------------------
    // Pin synchronisers for the asynchronous error events and the strap
    // ------------------------------------------------------------------
    // Two stages each: an event is seen at q one edge after the first stage samples it
    wire uncor_s;
    wire nonfatal_s;
    wire fatal_s;
    wire down_s;

    lsdc_sync u_sync_uncor
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (uncor_err),
        .q     (uncor_s)
    );

    lsdc_sync u_sync_nonfatal
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (rx_nonfatal),
        .q     (nonfatal_s)
    );

    lsdc_sync u_sync_fatal
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (rx_fatal),
        .q     (fatal_s)
    );

    // The strap is a pin too; containment access waits two edges after reset
    lsdc_sync u_sync_down
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (is_downstream),
        .q     (down_s)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg        pcipm_sup_r;
    reg        aspm_sup_r;
    reg        subst_sup_r;
    reg        pcipm_en_r;
    reg        aspm_en_r;
    reg [1:0]  trig_mode_r;
    reg        cpl_ur_r;
    reg        int_en_r;
    reg        cor_en_r;
    reg        st_trig_r;
    reg [1:0]  st_rsn_r;
    reg        st_int_r;
    reg        irq_r;
    reg        cor_r;
    reg        active_r;
    reg [31:0] rdata_r;
    reg        rvalid_r;
    reg [31:0] rdata_nxt;

    wire       fire;
    wire [1:0] reason;
    wire       hit_l1_cap  = cfg_addr == `LSDC_OFF_L1_CAP;
    wire       hit_l1_ctl  = cfg_addr == `LSDC_OFF_L1_CTL_ONE;
    wire       hit_capctl  = cfg_addr == `LSDC_OFF_CNT_CAP_CTL;
    wire       hit_status  = cfg_addr == `LSDC_OFF_CNT_STATUS;
    // Mode 11 is treated exactly like 00 so a stray value cannot arm it
    wire       trig_en     = down_s && (trig_mode_r == `LSDC_TRIG_FATAL
                             || trig_mode_r == `LSDC_TRIG_ANY);
    // Trigger is refused while a previous one is still pending
    wire       fire_new    = fire && !st_trig_r;
    wire       w1c_trig    = cfg_wr && down_s && hit_status && cfg_be[`LSDC_BE_LOW]
                             && cfg_wdata[`LSDC_ST_TRIG_BIT];
    wire       w1c_int     = cfg_wr && down_s && hit_status && cfg_be[`LSDC_BE_LOW]
                             && cfg_wdata[`LSDC_ST_INT_BIT];
    wire       w1c_rsn_lo  = cfg_wr && down_s && hit_status && cfg_be[`LSDC_BE_LOW]
                             && cfg_wdata[`LSDC_ST_RSN_LO];
    wire       w1c_rsn_hi  = cfg_wr && down_s && hit_status && cfg_be[`LSDC_BE_LOW]
                             && cfg_wdata[`LSDC_ST_RSN_HI];

    lsdc_trig u_trig
    (
        .trig_en     (trig_en),
        .trig_mode   (trig_mode_r),
        .uncor_err   (uncor_s),
        .rx_nonfatal (nonfatal_s),
        .rx_fatal    (fatal_s),
        .fire        (fire),
        .reason      (reason)
    );

    // ------------------------------------------------------------------
    // Capability defaults and autoload capture
    // ------------------------------------------------------------------
    // Autoload may rewrite the capability defaults at any time
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcipm_sup_r <= `LSDC_RST_PCIPM_SUP;
            aspm_sup_r  <= `LSDC_RST_ASPM_SUP;
            subst_sup_r <= `LSDC_RST_SUBST_SUP;
        end
        else
        begin
            if (ld_wr)
            begin
                pcipm_sup_r <= ld_sup[0];
                aspm_sup_r  <= ld_sup[1];
                subst_sup_r <= ld_sup[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcipm_en_r  <= 1'b0;
            aspm_en_r   <= 1'b0;
            trig_mode_r <= `LSDC_TRIG_OFF;
            cpl_ur_r    <= 1'b0;
            int_en_r    <= 1'b0;
            cor_en_r    <= 1'b0;
        end
        else if (cfg_wr)
        begin
            if (hit_l1_ctl && cfg_be[`LSDC_BE_LOW])
            begin
                pcipm_en_r <= cfg_wdata[`LSDC_L1_PCIPM_BIT];
                aspm_en_r  <= cfg_wdata[`LSDC_L1_ASPM_BIT];
            end
            // Containment control exists only on a downstream port
            if (hit_capctl && down_s && cfg_be[`LSDC_BE_CTL])
            begin
                trig_mode_r <= cfg_wdata[`LSDC_TRIG_HI:`LSDC_TRIG_LO];
                cpl_ur_r    <= cfg_wdata[`LSDC_CPL_BIT];
                int_en_r    <= cfg_wdata[`LSDC_INT_EN_BIT];
                cor_en_r    <= cfg_wdata[`LSDC_COR_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags; a new trigger wins over a clear in the same cycle
    // ------------------------------------------------------------------
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_trig_r <= 1'b0;
            st_rsn_r  <= `LSDC_RSN_UNCOR;
            st_int_r  <= 1'b0;
            irq_r     <= 1'b0;
            cor_r     <= 1'b0;
            active_r  <= 1'b0;
        end
        else
        begin
            irq_r <= fire_new && int_en_r;
            cor_r <= fire_new && cor_en_r;
            // Reason bits clear one by one; a pending trigger blocks new ones
            if (fire_new)
            begin
                st_trig_r <= 1'b1;
                st_rsn_r  <= reason;
            end
            else
            begin
                if (w1c_trig)
                    st_trig_r <= 1'b0;
                if (w1c_rsn_lo)
                    st_rsn_r[0] <= 1'b0;
                if (w1c_rsn_hi)
                    st_rsn_r[1] <= 1'b0;
            end
            if (fire_new && int_en_r)
                st_int_r <= 1'b1;
            else if (w1c_int)
                st_int_r <= 1'b0;
            active_r <= fire_new || (st_trig_r && !w1c_trig);
        end
    end

    // ------------------------------------------------------------------
    // Read path, one cycle after the strobe
    // ------------------------------------------------------------------
    always @*
    begin
        // Unmapped addresses and reserved bits fall out of this default
        rdata_nxt = 32'h00000000;
        if (hit_l1_cap)
        begin
            rdata_nxt[`LSDC_L1_PCIPM_BIT] = pcipm_sup_r;
            rdata_nxt[`LSDC_L1_ASPM_BIT]  = aspm_sup_r;
            rdata_nxt[`LSDC_L1_SUBST_BIT] = subst_sup_r;
        end
        else if (hit_l1_ctl)
        begin
            rdata_nxt[`LSDC_L1_PCIPM_BIT] = pcipm_en_r;
            rdata_nxt[`LSDC_L1_ASPM_BIT]  = aspm_en_r;
        end
        else if (down_s && cfg_addr == `LSDC_OFF_CNT_HDR)
        begin
            rdata_nxt = `LSDC_HDR_VALUE;
        end
        else if (down_s && hit_capctl)
        begin
            rdata_nxt[`LSDC_MSG_NUM_HI:`LSDC_MSG_NUM_LO] = `LSDC_MSG_NUM_RST;
            rdata_nxt[`LSDC_TRIG_HI:`LSDC_TRIG_LO]       = trig_mode_r;
            rdata_nxt[`LSDC_CPL_BIT]                     = cpl_ur_r;
            rdata_nxt[`LSDC_INT_EN_BIT]                  = int_en_r;
            rdata_nxt[`LSDC_COR_EN_BIT]                  = cor_en_r;
        end
        else if (down_s && hit_status)
        begin
            rdata_nxt[`LSDC_ST_TRIG_BIT]                = st_trig_r;
            rdata_nxt[`LSDC_ST_RSN_HI:`LSDC_ST_RSN_LO]  = st_rsn_r;
            rdata_nxt[`LSDC_ST_INT_BIT]                 = st_int_r;
        end
    end

    // Read data holds until the next read so the master may pick it up late
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r  <= 32'h00000000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= cfg_rd;
            if (cfg_rd)
                rdata_r <= rdata_nxt;
        end
    end

    assign cfg_rdata    = rdata_r;
    assign cfg_rvalid   = rvalid_r;
    assign pcipm_l11_en = pcipm_en_r;
    assign aspm_l11_en  = aspm_en_r;
    assign cont_active  = active_r;
    assign cpl_ur_sel   = cpl_ur_r;
    assign cont_irq     = irq_r;
    assign cont_err_cor = cor_r;

endmodule // lsdc_top

`default_nettype wire

// [core/lsdc_trig.v]
`timescale 1ns/10ps
`default_nettype none
`include "lsdc_regs.vh"

module lsdc_trig
(
    input  wire       trig_en,
    input  wire [1:0] trig_mode,
    input  wire       uncor_err,
    input  wire       rx_nonfatal,
    input  wire       rx_fatal,
    output reg        fire,
    output reg  [1:0] reason
);

    // Uncorrectable error has priority over messages arriving together
    always @*
    begin
        fire   = 1'b0;
        reason = `LSDC_RSN_UNCOR;
        if (trig_en)
        begin
            if (uncor_err)
            begin
                fire   = 1'b1;
                reason = `LSDC_RSN_UNCOR;
            end
            else if (rx_fatal)
            begin
                fire   = 1'b1;
                reason = `LSDC_RSN_FATAL;
            end
            else if (rx_nonfatal && trig_mode == `LSDC_TRIG_ANY)
            begin
                fire   = 1'b1;
                reason = `LSDC_RSN_NONFATAL;
            end
        end
    end

endmodule // lsdc_trig

`default_nettype wire

// [testbench/lsdc_chk.sv]
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------
// Port checks on the register slice
// --------------------------------------------------
module lsdc_chk
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        cfg_rd,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic        is_downstream,
    input wire logic        uncor_err,
    input wire logic        rx_nonfatal,
    input wire logic        rx_fatal,
    input wire logic        cont_active,
    input wire logic        cont_irq,
    input wire logic        cont_err_cor
);
    wire logic ev_any;
    assign ev_any = uncor_err | rx_nonfatal | rx_fatal;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        cfg_rd && cfg_addr == a;
    endsequence
    // Strap passes two stages, so it must have stood for two cycles already
    sequence s_ds;
        is_downstream && $past(is_downstream) && $past(is_downstream, 2);
    endsequence
    AST_HDR: assert property (s_rd(12'h250) ##0 s_ds |=> cfg_rdata == 32'h0001001D)
        else $error("header read wrong");
    AST_HIDE: assert property (s_rd(12'h250) ##0 !is_downstream && !$past(is_downstream) && !$past(is_downstream, 2) |=> cfg_rdata == 32'h0)
        else $error("header seen on upstream port");
    AST_MSGNUM: assert property (s_rd(12'h254) ##0 s_ds |=> cfg_rdata[15:0] == 16'h0001)
        else $error("message number wrong");
    AST_CTL2: assert property (s_rd(12'h24C) |=> cfg_rdata == 32'h0)
        else $error("control two not zero");
    AST_CAP_RSV: assert property (s_rd(12'h244) |=> cfg_rdata[31:5] == 27'h0 && !cfg_rdata[2] && !cfg_rdata[0])
        else $error("capability reserved bits set");
    AST_ST_RSV: assert property (s_rd(12'h258) |=> cfg_rdata[31:4] == 28'h0)
        else $error("status reserved bits set");
    AST_IRQ_ONE: assert property (cont_irq |-> $rose(cont_active) ##1 !cont_irq)
        else $error("interrupt pulse wrong");
    AST_COR_ONE: assert property (cont_err_cor |-> $rose(cont_active) ##1 !cont_err_cor)
        else $error("correctable pulse wrong");
    AST_CAUSE: assert property ($rose(cont_active) |-> $past(ev_any, 2) || $past(ev_any, 3) || $past(ev_any, 4))
        else $error("containment without event");
    AST_NO_UP: assert property (!is_downstream [*4] |-> !$rose(cont_active))
        else $error("containment on upstream port");
endmodule // lsdc_chk

bind lsdc_top lsdc_chk i_chk
(
    .mclk(mclk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata), .is_downstream(is_downstream), .uncor_err(uncor_err),
    .rx_nonfatal(rx_nonfatal), .rx_fatal(rx_fatal), .cont_active(cont_active),
    .cont_irq(cont_irq), .cont_err_cor(cont_err_cor)
);

`default_nettype wire

// [testbench/lsdc_evt_src.sv]
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------
// Link-side error event source
// --------------------------------------------------
module lsdc_evt_src
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       go,
    input wire logic [1:0] kind,
    output logic           uncor_err,
    output logic           rx_nonfatal,
    output logic           rx_fatal
);
    logic [2:0] left_r;
    logic [1:0] kind_r;
    // Four cycles: the design needs two to pass its synchroniser
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            left_r <= 3'h0;
        else if (go)
            left_r <= 3'h4;
        else if (left_r != 3'h0)
            left_r <= left_r - 3'h1;
    end
    always @(posedge mclk)
    begin
        if (go)
            kind_r <= kind;
    end
    assign uncor_err = left_r != 3'h0 && kind_r == 2'h0;
    assign rx_nonfatal = left_r != 3'h0 && kind_r == 2'h1;
    assign rx_fatal = left_r != 3'h0 && kind_r == 2'h2;
endmodule // lsdc_evt_src

`default_nettype wire

// [testbench/tb_lsdc_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_lsdc_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cfg_rd = 1'b0;
    logic        cfg_wr = 1'b0;
    logic [11:0] cfg_addr = 12'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [3:0]  cfg_be = 4'hF;
    logic        ld_wr = 1'b0;
    logic [2:0]  ld_sup = 3'h5;
    logic        is_downstream = 1'b1;
    logic        ev_go = 1'b0;
    logic [1:0]  ev_kind = 2'h0;
    logic [31:0] rd_q;
    wire logic   uncor_err, rx_nonfatal, rx_fatal, cfg_rvalid;
    wire logic   pcipm_l11_en, aspm_l11_en, cont_active, cpl_ur_sel, cont_irq, cont_err_cor;
    wire logic [31:0] cfg_rdata;
    integer      fails = 0;
    integer      total_checks = 0;

    always #2.5 mclk = ~mclk;

    lsdc_top i_dut
    (
        .mclk(mclk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .ld_wr(ld_wr), .ld_sup(ld_sup),
        .is_downstream(is_downstream), .uncor_err(uncor_err),
        .rx_nonfatal(rx_nonfatal), .rx_fatal(rx_fatal), .pcipm_l11_en(pcipm_l11_en),
        .aspm_l11_en(aspm_l11_en), .cont_active(cont_active), .cpl_ur_sel(cpl_ur_sel),
        .cont_irq(cont_irq), .cont_err_cor(cont_err_cor)
    );

    lsdc_evt_src i_evt
    (
        .mclk(mclk), .rst_n(rst_n), .go(ev_go), .kind(ev_kind), .uncor_err(uncor_err),
        .rx_nonfatal(rx_nonfatal), .rx_fatal(rx_fatal)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task automatic final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // --------------------------------------------------
    // Register access: one-cycle strobe, answer one cycle later
    // --------------------------------------------------
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        begin
            @(posedge mclk);
            cfg_rd <= !wr;
            cfg_wr <= wr;
            cfg_addr <= a;
            cfg_wdata <= d;
            cfg_be <= b;
            @(posedge mclk);
            cfg_rd <= 1'b0;
            cfg_wr <= 1'b0;
            @(negedge mclk);
            chk(32'(cfg_rvalid), 32'(!wr));
            rd_q = cfg_rdata;
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        begin
            acc(1'b0, a, 32'h0, 4'hF);
            chk(rd_q, exp);
        end
    endtask

    task automatic t_reset;
        begin
            rdchk(12'h244, 32'h12);
            rdchk(12'h248, 32'h0);
            rdchk(12'h24C, 32'h0);
            rdchk(12'h250, 32'h0001001D);
            rdchk(12'h254, 32'h1);
            rdchk(12'h258, 32'h0);
            rdchk(12'h25C, 32'h0);
        end
    endtask

    task automatic t_rw;
        begin
            acc(1'b1, 12'h248, 32'hFFFFFFFF, 4'hF);
            rdchk(12'h248, 32'hA);
            chk(32'(pcipm_l11_en & aspm_l11_en), 32'h1);
            acc(1'b1, 12'h248, 32'h8, 4'hF);
            rdchk(12'h248, 32'h8);
            chk(32'({pcipm_l11_en, aspm_l11_en}), 32'h1);
            // Byte two off: containment control must not move
            acc(1'b1, 12'h254, 32'hFFFFFFFF, 4'hB);
            rdchk(12'h254, 32'h1);
            acc(1'b1, 12'h254, 32'hFFFFFFFF, 4'hF);
            rdchk(12'h254, 32'h001F0001);
            chk(32'(cpl_ur_sel), 32'h1);
            acc(1'b1, 12'h254, 32'h0, 4'hF);
            rdchk(12'h254, 32'h1);
            chk(32'(cpl_ur_sel), 32'h0);
            acc(1'b1, 12'h244, 32'h0, 4'hF);
            acc(1'b1, 12'h24C, 32'hFFFFFFFF, 4'hF);
            rdchk(12'h244, 32'h12);
            rdchk(12'h24C, 32'h0);
        end
    endtask

    task automatic ld(input logic [2:0] v);
        begin
            @(posedge mclk);
            ld_wr <= 1'b1;
            ld_sup <= v;
            @(posedge mclk);
            ld_wr <= 1'b0;
        end
    endtask

    task automatic t_ld;
        begin
            ld(3'h2);
            rdchk(12'h244, 32'h8);
            ld(3'h5);
            rdchk(12'h244, 32'h12);
        end
    endtask

    task automatic trig(input logic [1:0] m, input logic ie, input logic ce,
                        input logic [1:0] k, input logic f, input logic [1:0] r);
        logic [31:0] ni;
        logic [31:0] nc;
        begin
            ni = 32'h0;
            nc = 32'h0;
            acc(1'b1, 12'h254, {11'h0, ce, ie, 1'b0, m, 16'h0}, 4'hF);
            @(posedge mclk);
            ev_go <= 1'b1;
            ev_kind <= k;
            @(posedge mclk);
            ev_go <= 1'b0;
            repeat (10)
            begin
                @(negedge mclk);
                ni = ni + 32'(cont_irq);
                nc = nc + 32'(cont_err_cor);
            end
            chk(ni, 32'(f & ie));
            chk(nc, 32'(f & ce));
            chk(32'(cont_active), 32'(f));
            rdchk(12'h258, f ? {28'h0, ie, r, 1'b1} : 32'h0);
            acc(1'b1, 12'h258, 32'hF, 4'h1);
            rdchk(12'h258, 32'h0);
        end
    endtask

    task automatic t_trig;
        begin
            trig(2'h1, 1'b1, 1'b0, 2'h2, 1'b1, 2'h2);
            trig(2'h1, 1'b1, 1'b1, 2'h1, 1'b0, 2'h0);
            trig(2'h1, 1'b0, 1'b1, 2'h0, 1'b1, 2'h0);
            trig(2'h2, 1'b0, 1'b1, 2'h1, 1'b1, 2'h1);
            trig(2'h2, 1'b1, 1'b1, 2'h2, 1'b1, 2'h2);
            trig(2'h2, 1'b1, 1'b0, 2'h0, 1'b1, 2'h0);
            trig(2'h0, 1'b1, 1'b1, 2'h2, 1'b0, 2'h0);
            trig(2'h3, 1'b1, 1'b1, 2'h0, 1'b0, 2'h0);
        end
    endtask

    task automatic t_up;
        begin
            @(posedge mclk);
            is_downstream <= 1'b0;
            repeat (2) @(posedge mclk);
            rdchk(12'h250, 32'h0);
            trig(2'h1, 1'b1, 1'b1, 2'h2, 1'b0, 2'h0);
            @(posedge mclk);
            is_downstream <= 1'b1;
        end
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset;
        t_rw;
        t_ld;
        t_trig;
        t_up;
        final_report;
    end
endmodule // tb_lsdc_top

`default_nettype wire
